// ---- fsp_bank.sv ----
// Fieldbus supervision parameter bank with watchdogs and limit monitors.
`timescale 1ns/1ps
module fsp_bank
    import fsp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_ack,
    output logic             reg_err,
    input  wire fsp_limits_t limits,
    input  wire logic        serial_msg,
    input  wire logic        scan_msg,
    input  wire logic        ref_active,
    input  wire logic [15:0] follow_distance,
    input  wire logic [15:0] dc_bus_voltage,
    input  wire logic        error_clear,
    output fsp_frame_t       frame_active,
    output logic             word_order_active,
    output logic             serial_guard_error,
    output logic             scan_guard_error,
    output logic             follow_error,
    output logic             quick_stop,
    output logic             drive_off,
    output logic             ctrl_reset_pulse
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [15:0] serial_frame_format;
    logic [15:0] serial_link_watchdog;
    logic [15:0] tcp_word_order;
    logic [15:0] scan_link_watchdog;
    logic [15:0] max_follow_distance;
    logic [15:0] controller_param_reset;
    logic        fmt_latched;

    // ------------------------------------------------------------------
    // Address decode and write qualification
    // ------------------------------------------------------------------
    wire hit_fmt   = reg_addr == ADDR_FRAME_FMT;
    wire hit_ser   = reg_addr == ADDR_SER_WDOG;
    wire hit_ord   = reg_addr == ADDR_WORD_ORDER;
    wire hit_scan  = reg_addr == ADDR_SCAN_WDOG;
    wire hit_dist  = reg_addr == ADDR_MAX_DIST;
    wire hit_ctrl  = reg_addr == ADDR_CTRL_RESET;
    wire hit_ro    = reg_addr == ADDR_DC_MAX || reg_addr == ADDR_DC_OFF ||
                     reg_addr == ADDR_DC_QSTOP ||
                     reg_addr == ADDR_TEMP_WARN ||
                     reg_addr == ADDR_TEMP_LIMIT;
    wire hit_rw    = hit_fmt | hit_ser | hit_ord | hit_scan | hit_dist |
                     hit_ctrl;

    // Out-of-range values are refused whole so a bad write never leaves
    // a setting the block cannot honour.
    wire fmt_ok    = reg_wdata >= FMT_MIN && reg_wdata <= FMT_MAX;
    wire wdog_ok   = reg_wdata <= WDOG_MAX;
    wire ord_ok    = reg_wdata <= WORD_ORDER_MAX;
    wire dist_ok   = reg_wdata <= DIST_MAX;
    wire ctrl_ok   = reg_wdata <= CTRL_RESET_MAX;
    wire val_ok    = hit_fmt  ? fmt_ok  :
                     hit_ser  ? wdog_ok :
                     hit_scan ? wdog_ok :
                     hit_ord  ? ord_ok  :
                     hit_dist ? dist_ok : ctrl_ok;
    wire wr_good   = reg_wr & hit_rw & val_ok;
    wire wr_bad    = reg_wr & ~(hit_rw & val_ok);
    wire rd_good   = reg_rd & ~reg_wr & (hit_rw | hit_ro);
    wire rd_bad    = reg_rd & ~reg_wr & ~(hit_rw | hit_ro);

    wire [15:0] rd_mux =
        hit_fmt  ? serial_frame_format    :
        hit_ser  ? serial_link_watchdog   :
        hit_ord  ? tcp_word_order         :
        hit_scan ? scan_link_watchdog     :
        hit_dist ? max_follow_distance    :
        hit_ctrl ? controller_param_reset :
        reg_addr == ADDR_DC_MAX     ? limits.dc_max     :
        reg_addr == ADDR_DC_OFF     ? limits.dc_off     :
        reg_addr == ADDR_DC_QSTOP   ? limits.dc_qstop   :
        reg_addr == ADDR_TEMP_WARN  ? limits.temp_warn  :
        reg_addr == ADDR_TEMP_LIMIT ? limits.temp_limit : 16'h0000;

    // ------------------------------------------------------------------
    // Register writes and bus answer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            serial_frame_format    <= RST_FRAME_FMT;
            serial_link_watchdog   <= RST_SER_WDOG;
            tcp_word_order         <= RST_WORD_ORDER;
            scan_link_watchdog     <= RST_SCAN_WDOG;
            max_follow_distance    <= RST_MAX_DIST;
            controller_param_reset <= 16'h0000;
        end else if (wr_good) begin
            if (hit_fmt)  serial_frame_format  <= reg_wdata;
            if (hit_ser)  serial_link_watchdog <= reg_wdata;
            if (hit_ord)  tcp_word_order       <= reg_wdata;
            if (hit_scan) scan_link_watchdog   <= reg_wdata;
            if (hit_dist) max_follow_distance  <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
            reg_ack   <= 1'b0;
            reg_err   <= 1'b0;
        end else begin
            reg_rdata <= rd_good ? rd_mux : 16'h0000;
            reg_ack   <= wr_good | rd_good;
            reg_err   <= wr_bad | rd_bad;
        end
    end

    // Writing 0 has no effect; writing 1 gives a single command pulse.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_reset_pulse <= 1'b0;
        end else begin
            ctrl_reset_pulse <= wr_good & hit_ctrl & reg_wdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Frame format and word order
    // ------------------------------------------------------------------
    // The format is captured once after reset release, which stands in
    // for power-up; later writes are stored but not applied.
    fsp_frame_t next_frame;
    always_comb begin
        next_frame.data_bits = FRAME_DATA_BITS;
        next_frame.parity    = FSP_PAR_NONE;
        next_frame.stop_bits = 2'd1;
        case (serial_frame_format)
            FMT_NONE_1STOP: next_frame.parity = FSP_PAR_NONE;
            FMT_EVEN_1STOP: next_frame.parity = FSP_PAR_EVEN;
            FMT_ODD_1STOP:  next_frame.parity = FSP_PAR_ODD;
            FMT_NONE_2STOP: next_frame.stop_bits = 2'd2;
            default:        next_frame.parity = FSP_PAR_EVEN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fmt_latched  <= 1'b0;
            frame_active <= '0;
        end else if (!fmt_latched) begin
            fmt_latched  <= 1'b1;
            frame_active <= next_frame;
        end
    end

    assign word_order_active = tcp_word_order[0];

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    logic [15:0] tick_cnt;
    wire         ms_tick = tick_cnt == TICK_CYCLES - 16'd1;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= ms_tick ? 16'h0000 : tick_cnt + 16'd1;
        end
    end

    // ------------------------------------------------------------------
    // Link watchdogs
    // ------------------------------------------------------------------
    // The serial watchdog arms at its first message as the scan one does,
    // so a master that has not yet spoken is not blamed.
    logic [15:0] ser_ms;
    logic        ser_armed;
    logic [15:0] scan_ms;
    logic        scan_armed;

    wire ser_on   = serial_link_watchdog != 16'h0000;
    wire scan_on  = scan_link_watchdog != 16'h0000;
    wire ser_hit  = ser_armed & ser_on & ms_tick &
                    ser_ms + 16'd1 >= serial_link_watchdog;
    wire scan_hit = scan_armed & scan_on & ms_tick &
                    scan_ms + 16'd1 >= scan_link_watchdog;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ser_ms             <= 16'h0000;
            ser_armed          <= 1'b0;
            serial_guard_error <= 1'b0;
        end else begin
            if (serial_msg) begin
                ser_ms    <= 16'h0000;
                ser_armed <= 1'b1;
            end else if (ser_hit) begin
                ser_armed <= 1'b0;
            end else if (ser_armed && ms_tick) begin
                ser_ms    <= ser_ms + 16'd1;
            end
            if (ser_hit)
                serial_guard_error <= 1'b1;
            else if (error_clear)
                serial_guard_error <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            scan_ms          <= 16'h0000;
            scan_armed       <= 1'b0;
            scan_guard_error <= 1'b0;
        end else begin
            if (scan_msg) begin
                scan_ms    <= 16'h0000;
                scan_armed <= 1'b1;
            end else if (scan_hit) begin
                scan_armed <= 1'b0;
            end else if (scan_armed && ms_tick) begin
                scan_ms    <= scan_ms + 16'd1;
            end
            if (scan_hit)
                scan_guard_error <= 1'b1;
            else if (error_clear)
                scan_guard_error <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Following distance and DC bus monitors
    // ------------------------------------------------------------------
    wire dist_on   = max_follow_distance != 16'h0000;
    wire dist_trip = dist_on & ref_active &
                     follow_distance > max_follow_distance;
    wire dc_stop   = dc_bus_voltage <= limits.dc_qstop;
    wire dc_off    = dc_bus_voltage <= limits.dc_off;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            follow_error <= 1'b0;
            quick_stop   <= 1'b0;
            drive_off    <= 1'b0;
        end else begin
            if (dist_trip)
                follow_error <= 1'b1;
            else if (error_clear)
                follow_error <= 1'b0;
            quick_stop <= dc_stop;
            drive_off  <= dc_off;
        end
    end

endmodule : fsp_bank

// ---- fsp_pkg.sv ----
// Package with register map, field values and timing for the parameter bank.
package fsp_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_CTRL_RESET   = 16'h040e;
    localparam logic [15:0] ADDR_DC_MAX       = 16'h1006;
    localparam logic [15:0] ADDR_DC_OFF       = 16'h1008;
    localparam logic [15:0] ADDR_TEMP_WARN    = 16'h100c;
    localparam logic [15:0] ADDR_TEMP_LIMIT   = 16'h100e;
    localparam logic [15:0] ADDR_DC_QSTOP     = 16'h1014;
    localparam logic [15:0] ADDR_FRAME_FMT    = 16'h160a;
    localparam logic [15:0] ADDR_SER_WDOG     = 16'h160c;
    localparam logic [15:0] ADDR_WORD_ORDER   = 16'h190a;
    localparam logic [15:0] ADDR_SCAN_WDOG    = 16'h190e;
    localparam logic [15:0] ADDR_MAX_DIST     = 16'h2e06;

    // ------------------------------------------------------------------
    // Reset values and legal ranges
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_FRAME_FMT     = 16'h0002;
    localparam logic [15:0] RST_SER_WDOG      = 16'h0000;
    localparam logic [15:0] RST_WORD_ORDER    = 16'h0000;
    localparam logic [15:0] RST_SCAN_WDOG     = 16'h0000;
    localparam logic [15:0] RST_MAX_DIST      = 16'h000a;
    localparam logic [15:0] RST_TEMP          = 16'h0000;
    localparam logic [15:0] FMT_MIN           = 16'h0001;
    localparam logic [15:0] FMT_MAX           = 16'h0004;
    localparam logic [15:0] WDOG_MAX          = 16'h2710;
    localparam logic [15:0] DIST_MAX          = 16'h270f;
    localparam logic [15:0] WORD_ORDER_MAX    = 16'h0001;
    localparam logic [15:0] CTRL_RESET_MAX    = 16'h0001;

    // ------------------------------------------------------------------
    // Frame format codes and word order values
    // ------------------------------------------------------------------
    localparam logic [15:0] FMT_NONE_1STOP    = 16'h0001;
    localparam logic [15:0] FMT_EVEN_1STOP    = 16'h0002;
    localparam logic [15:0] FMT_ODD_1STOP     = 16'h0003;
    localparam logic [15:0] FMT_NONE_2STOP    = 16'h0004;
    localparam logic        HIGH_WORD_FIRST   = 1'b0;
    localparam logic        LOW_WORD_FIRST    = 1'b1;
    localparam logic [3:0]  FRAME_DATA_BITS   = 4'h8;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ            = 40_000_000;
    localparam int          TICK_MS           = 1;
    localparam int          TICK_CYCLES_INT   = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] TICK_CYCLES       = 16'(TICK_CYCLES_INT);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FSP_PAR_NONE,
        FSP_PAR_EVEN,
        FSP_PAR_ODD
    } fsp_parity_t;

    typedef struct packed {
        logic [3:0]  data_bits;
        fsp_parity_t parity;
        logic [1:0]  stop_bits;
    } fsp_frame_t;

    typedef struct packed {
        logic [15:0] dc_max;
        logic [15:0] dc_off;
        logic [15:0] dc_qstop;
        logic [15:0] temp_warn;
        logic [15:0] temp_limit;
    } fsp_limits_t;

endpackage : fsp_pkg

// ---- fsp_bank_chk.sv ----
// Concurrent checks on the parameter bank ports.
`timescale 1ns/1ps
module fsp_bank_chk
    import fsp_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        reg_err,
    input wire logic        reg_rd,
    input wire fsp_limits_t limits,
    input wire logic        ref_active,
    input wire logic [15:0] follow_distance,
    input wire logic [15:0] dc_bus_voltage,
    input wire fsp_frame_t  frame_active,
    input wire logic        word_order_active,
    input wire logic        scan_guard_error,
    input wire logic        follow_error,
    input wire logic        quick_stop,
    input wire logic        drive_off,
    input wire logic        ctrl_reset_pulse
);
    logic [1:0]  rst_d;
    logic [15:0] dist_max;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // The shadow follows accepted writes on the taking edge, as the bank does.
    always_ff @(posedge sys_clk) begin
        rst_d <= {rst_d[0], sys_rst};
        if (sys_rst)
            dist_max <= RST_MAX_DIST;
        else if (reg_wr && reg_addr == ADDR_MAX_DIST && reg_wdata <= DIST_MAX)
            dist_max <= reg_wdata;
    end
    AST_FMT_HOLD: assert property (
        rst_d == 2'h0 |-> $stable(frame_active))
        else $error("active frame format changed after start");
    AST_FMT_LEGAL: assert property (
        rst_d == 2'h0 |-> frame_active.data_bits == FRAME_DATA_BITS &&
        ((frame_active.stop_bits == 2'h1 && frame_active.parity != 2'h3) ||
        (frame_active.stop_bits == 2'h2 && frame_active.parity == 2'h0)))
        else $error("active frame format is not a legal code");
    AST_WORD_ORDER: assert property (
        (reg_wr && reg_addr == ADDR_WORD_ORDER && reg_wdata <= 16'h0001)
        |=> word_order_active == $past(reg_wdata[0]))
        else $error("word order output does not follow write");
    AST_FOLLOW_SET: assert property (
        (ref_active && follow_distance > dist_max && dist_max != 16'h0000)
        |=> follow_error)
        else $error("following error not raised");
    AST_FOLLOW_OFF: assert property (
        (!follow_error && dist_max == 16'h0000) |=> !follow_error)
        else $error("following error raised with monitoring off");
    AST_QSTOP: assert property (
        !$past(sys_rst) |->
        quick_stop == ($past(dc_bus_voltage) <= $past(limits.dc_qstop)))
        else $error("quick stop does not match bus voltage");
    AST_DRIVE_OFF: assert property (
        !$past(sys_rst) |->
        drive_off == ($past(dc_bus_voltage) <= $past(limits.dc_off)))
        else $error("drive off does not match bus voltage");
    AST_CTRL_PULSE: assert property (
        !$past(sys_rst) |-> ctrl_reset_pulse == ($past(reg_wr) &&
        $past(reg_addr) == ADDR_CTRL_RESET && $past(reg_wdata) == 16'h0001))
        else $error("controller reset pulse wrong");
    AST_WDOG_REFUSE: assert property (
        (reg_wr && reg_wdata > WDOG_MAX && (reg_addr == ADDR_SER_WDOG ||
        reg_addr == ADDR_SCAN_WDOG)) |=> reg_err && !reg_ack)
        else $error("watchdog value above limit accepted");
    AST_TEMP_RO: assert property (
        (reg_rd && !reg_wr && reg_addr == ADDR_TEMP_WARN)
        |=> reg_ack && reg_rdata == $past(limits.temp_warn))
        else $error("temperature warning read wrong");
    cover property ($rose(follow_error));
    cover property ($rose(scan_guard_error));
    cover property (ctrl_reset_pulse);
    cover property ($rose(quick_stop));
endmodule : fsp_bank_chk

bind fsp_bank fsp_bank_chk i_chk (.*);

// ---- fsp_master.sv ----
// Register bus master model issuing single accesses to the bank.
`timescale 1ns/1ps
module fsp_master
    import fsp_pkg::*;
(
    input  wire logic        sys_clk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack,
    input  wire logic        reg_err
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // Strobe one cycle; the answer stands in the next cycle only.
    task automatic access(input logic wr, input logic [15:0] addr, data,
                          output logic [15:0] rdata, output logic ack, err);
        @(negedge sys_clk);
        reg_wr    = wr;
        reg_rd    = !wr;
        reg_addr  = addr;
        reg_wdata = data;
        @(negedge sys_clk);
        rdata     = reg_rdata;
        ack       = reg_ack;
        err       = reg_err;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // Released lines carry the inverse so stale values never match.
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask : access
endmodule : fsp_master

// ---- fsp_bank_tb_top.sv ----
// Self-checking testbench for the parameter bank.
`timescale 1ns/1ps
module fsp_bank_tb_top;
    import fsp_pkg::*;
    logic        sys_clk, sys_rst, reg_wr, reg_rd, reg_ack, reg_err, ack, err;
    logic        serial_msg, scan_msg, ref_active, error_clear;
    logic        word_order_active, serial_guard_error, scan_guard_error;
    logic        follow_error, quick_stop, drive_off, ctrl_reset_pulse;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, follow_distance;
    logic [15:0] dc_bus_voltage, rd_val;
    fsp_limits_t limits;
    fsp_frame_t  frame_active;
    int          miscompares = 0;
    int          comparisons = 0;
    int          n;
    localparam logic [15:0] RA [6] = '{ADDR_FRAME_FMT, ADDR_SER_WDOG,
        ADDR_WORD_ORDER, ADDR_SCAN_WDOG, ADDR_MAX_DIST, ADDR_CTRL_RESET};
    localparam logic [15:0] RV [6] = '{16'h0002, 16'h0000, 16'h0000,
        16'h0000, 16'h000a, 16'h0000};
    localparam logic [15:0] BAD [6] = '{16'h0005, 16'h2711, 16'h0002,
        16'h2711, 16'h2710, 16'h0002};
    localparam logic [15:0] TOP [6] = '{16'h0004, 16'h2710, 16'h0001,
        16'h2710, 16'h270f, 16'h0001};
    localparam logic [15:0] DCV [4] = '{16'h0065, 16'h0064, 16'h0051,
        16'h0050};
    localparam fsp_frame_t EVEN_FRAME = '{FRAME_DATA_BITS, FSP_PAR_EVEN, 2'h1};

    fsp_bank   i_dut (.*);
    fsp_master i_mst (.*);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, expected);
        comparisons++;
        if (seen !== expected) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h",
                     $time, seen, expected);
        end
    endtask : check

    task automatic wr(input logic [15:0] addr, data, input logic exp_err);
        i_mst.access(1'b1, addr, data, rd_val, ack, err);
        check(16'({ack, err}), 16'({!exp_err, exp_err}));
    endtask : wr

    task automatic rd(input logic [15:0] addr, expected);
        i_mst.access(1'b0, addr, 16'h0000, rd_val, ack, err);
        check(16'({ack, err}), 16'h0002);
        check(rd_val, expected);
    endtask : rd

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic tick(input int cycles);
        repeat (cycles) @(negedge sys_clk);
    endtask : tick

    initial begin
        {sys_rst, serial_msg, scan_msg, ref_active, error_clear} = 5'h10;
        limits = '{16'h0258, 16'h0050, 16'h0064, 16'hfff6, 16'h0055};
        follow_distance = 16'h0000;
        dc_bus_voltage  = 16'h0200;
        tick(5);
        sys_rst = 1'b0;
        tick(2);
        check(16'(frame_active), 16'(EVEN_FRAME));
        wr(ADDR_FRAME_FMT, 16'h0000, 1'b1);
        for (int c = 1; c <= 4; c++) wr(ADDR_FRAME_FMT, 16'(c), 1'b0);
        for (int i = 0; i < 6; i++) begin
            rd(RA[i], (i == 0) ? 16'h0004 : RV[i]);
            wr(RA[i], BAD[i], 1'b1);
            rd(RA[i], (i == 0) ? 16'h0004 : RV[i]);
            wr(RA[i], TOP[i], 1'b0);
            rd(RA[i], (i == 5) ? 16'h0000 : TOP[i]);
        end
        check(16'(frame_active), 16'(EVEN_FRAME));
        check(16'(word_order_active), 16'(LOW_WORD_FIRST));
        wr(ADDR_WORD_ORDER, 16'h0000, 1'b0);
        check(16'(word_order_active), 16'(HIGH_WORD_FIRST));
        rd(ADDR_TEMP_WARN, 16'hfff6);
        rd(ADDR_TEMP_LIMIT, 16'h0055);
        rd(ADDR_DC_OFF, 16'h0050);
        rd(ADDR_DC_QSTOP, 16'h0064);
        rd(ADDR_DC_MAX, 16'h0258);
        wr(ADDR_TEMP_LIMIT, 16'h0001, 1'b1);
        wr(16'h0000, 16'h0001, 1'b1);
        wr(ADDR_MAX_DIST, 16'h0005, 1'b0);
        {ref_active, follow_distance} = {1'b1, 16'h0005};
        tick(2);
        check(16'(follow_error), 16'h0000);
        follow_distance = 16'h0006;
        tick(2);
        check(16'(follow_error), 16'h0001);
        {ref_active, error_clear} = 2'h1;
        tick(1);
        error_clear = 1'b0;
        wr(ADDR_MAX_DIST, 16'h0000, 1'b0);
        {ref_active, follow_distance} = {1'b1, 16'hffff};
        tick(3);
        check(16'(follow_error), 16'h0000);
        ref_active = 1'b0;
        for (int i = 0; i < 4; i++) begin
            dc_bus_voltage = DCV[i];
            tick(2);
            check(16'(quick_stop), 16'(i > 0));
            check(16'(drive_off), 16'(i == 3));
        end
        wr(ADDR_SER_WDOG, 16'h0001, 1'b0);
        wr(ADDR_SCAN_WDOG, 16'h0001, 1'b0);
        tick(41000);
        check(16'({serial_guard_error, scan_guard_error}), 16'h0000);
        {serial_msg, scan_msg} = 2'h3;
        tick(1);
        {serial_msg, scan_msg} = 2'h0;
        n = 0;
        while ({serial_guard_error, scan_guard_error} !== 2'h3 &&
               n < 40002) begin
            tick(1);
            n++;
        end
        if (n == 40002) begin
            miscompares++;
            report_and_stop();
        end
        check(16'({serial_guard_error, scan_guard_error}), 16'h0003);
        error_clear = 1'b1;
        tick(1);
        error_clear = 1'b0;
        tick(100);
        check(16'({serial_guard_error, scan_guard_error}), 16'h0000);
        report_and_stop();
    end
endmodule : fsp_bank_tb_top
